// File: hdl/csc_pkg.sv
`default_nettype none
package csc_pkg;

   // ==========================================================================
   // Register map and bus widths
   // ==========================================================================
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;

   localparam logic [7:0] ADDR_CLOCK_CONTROL_ZERO   = 8'h06;
   localparam logic [7:0] ADDR_CLOCK_CONTROL_ONE    = 8'h07;
   localparam logic [7:0] ADDR_OSC_CONTROL          = 8'h08;
   localparam logic [7:0] ADDR_WRITE_PROTECT        = 8'h0A;

   // ==========================================================================
   // Reset values and writable-bit masks
   // ==========================================================================
   localparam logic [7:0] RST_CLOCK_CONTROL_ZERO    = 8'h58;
   localparam logic [7:0] RST_CLOCK_CONTROL_ONE     = 8'h00;
   localparam logic [7:0] RST_OSC_CONTROL           = 8'hA0;
   localparam logic [7:0] RST_WRITE_PROTECT         = 8'h00;

   localparam logic [7:0] MASK_CLOCK_CONTROL_ZERO   = 8'hDE;
   localparam logic [7:0] MASK_CLOCK_CONTROL_ONE    = 8'hC1;
   localparam logic [7:0] MASK_OSC_CONTROL          = 8'hF7;
   localparam logic [7:0] MASK_WRITE_PROTECT        = 8'h01;

   // ==========================================================================
   // Field positions
   // ==========================================================================
   localparam int unsigned POS_WAIT_PERIPH_CLK_GATE  = 2;
   localparam int unsigned POS_XTAL_DRIVE_STRENGTH   = 3;
   localparam int unsigned POS_XTAL_PIN_FUNCTION_SEL = 4;
   localparam int unsigned POS_SYSCLK_DIV8_SEL       = 6;
   localparam int unsigned POS_ALL_CLOCK_STOP        = 0;
   localparam int unsigned POS_SYSCLK_DIV_FIELD_LO   = 6;
   localparam int unsigned POS_XTAL_STOP             = 0;
   localparam int unsigned POS_FAST_OSC_ON           = 1;
   localparam int unsigned POS_SLOW_OSC_STOP         = 2;
   localparam int unsigned POS_CPU_SRC_LO            = 4;
   localparam int unsigned POS_PERIPH_SRC_LO         = 6;
   localparam int unsigned POS_CLK_REG_WRITE_UNLOCK  = 0;

   // ==========================================================================
   // Clock source codes and divider terminal counts
   // ==========================================================================
   localparam logic [1:0] SRC_XTAL = 2'h0;
   localparam logic [1:0] SRC_FAST = 2'h1;
   localparam logic [1:0] SRC_SLOW = 2'h2;

   localparam logic [3:0] TERM_DIV1  = 4'h0;
   localparam logic [3:0] TERM_DIV2  = 4'h1;
   localparam logic [3:0] TERM_DIV4  = 4'h3;
   localparam logic [3:0] TERM_DIV8  = 4'h7;
   localparam logic [3:0] TERM_DIV16 = 4'hF;

   typedef enum logic {
      CSC_RUN,
      CSC_STOP
   } csc_mode_type;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr_stb;
      logic              rd_stb;
   } csc_bus_req_type;

   typedef struct packed {
      logic out;
      logic dir;
   } csc_port_drive_type;

   typedef struct packed {
      logic val;
      logic oe_b;
   } csc_pin_out_type;

endpackage
`default_nettype wire

// File: hdl/csc_clock_source_control.sv
// Overview of operation
// (R01) Each of the three oscillators stops, restarts and serves as CPU or peripheral source.
// (R02) With the crystal unused, both shared pins act as ordinary port pins.
// (R03) Software selects the crystal-pin function before feeding an external clock.
// (R04) Wait-gate bit 1 stops the peripheral clock in wait mode; 0 keeps it.
// (R05) Drive-strength bit 0 gives low crystal drive, 1 gives high drive.
// (R06) Pin-function bit 0 routes pins to port logic, 1 to the crystal.
// (R07) Divide-by-8 bit 1 divides by 8; 0 defers to the two-bit divider field.
// (R08) Control register zero is written only while the write unlock bit is 1.
// (R09) Entering stop mode forces drive strength to high.
// (R10) Entering stop mode forces the divide-by-8 bit to 1.
// (R11) Stop mode with crystal function: input pin floats, output pin driven high.
// (R12) Stop mode with port function: both pins keep their direction and level.
// (R13) Bits 0 and 5 read as 0; bits 1 and 7 are written as 0.
// (R14) Software changes drive strength only once the crystal has settled.
// (R15) For the crystal, software sets pin function 1 and disables the input pull-up.
// (R16) Divider field: 00 none, 01 by 2, 10 by 4, 11 by 16.
// (R17) All-clock-stop bit 1 halts every clock and enters stop mode.
`timescale 1ns/100ps
`default_nettype none
module csc_clock_source_control (
   input  wire logic                      CORE_CLK_I,
   input  wire logic                      RST_B_I,
   input  wire logic [csc_pkg::ADDR_W-1:0] ADDR_I,
   input  wire logic [csc_pkg::DATA_W-1:0] WR_DATA_I,
   input  wire logic                      WR_STB_I,
   input  wire logic                      RD_STB_I,
   output var  logic [csc_pkg::DATA_W-1:0] RD_DATA_O,
   input  wire logic                      WAIT_MODE_I,
   input  wire logic                      WAKE_I,
   input  wire logic                      PORT_A_OUT_I,
   input  wire logic                      PORT_A_DIR_I,
   input  wire logic                      PORT_B_OUT_I,
   input  wire logic                      PORT_B_DIR_I,
   output var  logic                      PORT_A_IN_O,
   output var  logic                      PORT_B_IN_O,
   input  wire logic                      SHARED_PIN_A_I,
   input  wire logic                      SHARED_PIN_B_I,
   output var  logic                      SHARED_PIN_A_O,
   output var  logic                      SHARED_PIN_A_OE_B_O,
   output var  logic                      SHARED_PIN_B_O,
   output var  logic                      SHARED_PIN_B_OE_B_O,
   output var  logic                      XTAL_OSC_EN_O,
   output var  logic                      XTAL_DRIVE_HIGH_O,
   output var  logic                      FAST_OSC_EN_O,
   output var  logic                      SLOW_OSC_EN_O,
   output var  logic [1:0]                CPU_SRC_SEL_O,
   output var  logic [1:0]                PERIPH_SRC_SEL_O,
   output var  logic                      SYS_CLK_EN_O,
   output var  logic                      PERIPH_CLK_EN_O,
   output var  logic                      STOP_MODE_O
);
   import csc_pkg::*;

   // ==========================================================================
   // State
   // ==========================================================================
   typedef struct packed {
      csc_mode_type       mode;
      logic [7:0]         ctl0;
      logic [7:0]         ctl1;
      logic [7:0]         osc;
      logic [7:0]         prot;
      logic [7:0]         rd_data;
      logic [3:0]         div_cnt;
      logic               sys_en;
      logic               periph_en;
      logic [2:0]         sync_a;
      logic [2:0]         sync_b;
      logic [2:0]         sync_wake;
      logic               flt_a;
      logic               flt_b;
      logic               flt_wake;
      csc_port_drive_type hold_a;
      csc_port_drive_type hold_b;
      csc_pin_out_type    pin_a;
      csc_pin_out_type    pin_b;
      logic               xtal_en;
      logic               fast_en;
      logic               slow_en;
   } csc_state_type;

   localparam csc_state_type STATE_RST = '{
      mode:      CSC_RUN,
      ctl0:      RST_CLOCK_CONTROL_ZERO,
      ctl1:      RST_CLOCK_CONTROL_ONE,
      osc:       RST_OSC_CONTROL,
      prot:      RST_WRITE_PROTECT,
      pin_a:     '{val: 1'b0, oe_b: 1'b1},
      pin_b:     '{val: 1'b0, oe_b: 1'b1},
      xtal_en:   1'b1,
      slow_en:   1'b1,
      default:   '0
   };

   // Divide-by-8 overrides the two-bit field, which itself skips divide-by-8.
   function automatic logic [3:0] div_term(input logic div8, input logic [1:0] field);
      logic [3:0] t;
      t = TERM_DIV1;
      if (div8) begin
         t = TERM_DIV8;
      end else begin
         case (field)
            2'h0:    t = TERM_DIV1;
            2'h1:    t = TERM_DIV2;
            2'h2:    t = TERM_DIV4;
            2'h3:    t = TERM_DIV16;
            default: t = TERM_DIV1;
         endcase
      end
      return t;
   endfunction

   logic          rst_s1_q;
   logic          rst_b;
   csc_state_type s_q;
   csc_state_type s_d;
   csc_bus_req_type bus;
   logic          stop_now;
   logic          enter_stop;

   // ==========================================================================
   // Reset release
   // ==========================================================================
   always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         rst_s1_q <= 1'b0;
         rst_b    <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_b    <= rst_s1_q;
      end
   end

   // ==========================================================================
   // Next-state logic
   // ==========================================================================
   assign bus = '{addr: ADDR_I, wdata: WR_DATA_I, wr_stb: WR_STB_I, rd_stb: RD_STB_I};
   assign enter_stop = (s_q.mode == CSC_RUN) && bus.wr_stb && (bus.addr == ADDR_CLOCK_CONTROL_ONE)
                       && bus.wdata[POS_ALL_CLOCK_STOP];

   always_comb begin
      s_d      = s_q;
      stop_now = 1'b0;

      // Pins from outside pass three flops; a change counts once stages two and three agree.
      s_d.sync_a    = {s_q.sync_a[1:0], SHARED_PIN_A_I};
      s_d.sync_b    = {s_q.sync_b[1:0], SHARED_PIN_B_I};
      s_d.sync_wake = {s_q.sync_wake[1:0], WAKE_I};
      if (s_q.sync_a[1] == s_q.sync_a[2]) begin
         s_d.flt_a = s_q.sync_a[2];
      end
      if (s_q.sync_b[1] == s_q.sync_b[2]) begin
         s_d.flt_b = s_q.sync_b[2];
      end
      if (s_q.sync_wake[1] == s_q.sync_wake[2]) begin
         s_d.flt_wake = s_q.sync_wake[2];
      end

      // Register writes.
      if (bus.wr_stb) begin
         case (bus.addr)
            ADDR_CLOCK_CONTROL_ZERO: begin
               if (s_q.prot[POS_CLK_REG_WRITE_UNLOCK]) begin                    // [R08]
                  s_d.ctl0 = bus.wdata & MASK_CLOCK_CONTROL_ZERO;                // [R13]
               end
            end
            ADDR_CLOCK_CONTROL_ONE: s_d.ctl1 = bus.wdata & MASK_CLOCK_CONTROL_ONE;
            ADDR_OSC_CONTROL:       s_d.osc  = bus.wdata & MASK_OSC_CONTROL;     // [R01]
            ADDR_WRITE_PROTECT:     s_d.prot = bus.wdata & MASK_WRITE_PROTECT;
            default:                s_d.ctl1 = s_d.ctl1;
         endcase
      end

      // Stop-mode sequencing.
      case (s_q.mode)
         CSC_RUN: begin
            if (enter_stop) begin                                              // [R17]
               s_d.mode = CSC_STOP;
               s_d.ctl0[POS_XTAL_DRIVE_STRENGTH] = 1'b1;                        // [R09]
               s_d.ctl0[POS_SYSCLK_DIV8_SEL]     = 1'b1;                        // [R10]
               s_d.hold_a = '{out: PORT_A_OUT_I, dir: PORT_A_DIR_I};            // [R12]
               s_d.hold_b = '{out: PORT_B_OUT_I, dir: PORT_B_DIR_I};            // [R12]
            end
         end
         CSC_STOP: begin
            stop_now = 1'b1;
            // Wake wins over a stop write in the same cycle; the wake pin is a level.
            if (s_q.flt_wake) begin
               s_d.mode = CSC_RUN;
               s_d.ctl1[POS_ALL_CLOCK_STOP] = 1'b0;
            end
         end
         default: s_d.mode = CSC_RUN;
      endcase

      // Oscillator enables: all halt in stop mode.
      s_d.xtal_en = !stop_now && !enter_stop && s_q.ctl0[POS_XTAL_PIN_FUNCTION_SEL]
                    && !s_q.osc[POS_XTAL_STOP];                                  // [R01] [R17]
      s_d.fast_en = !stop_now && !enter_stop && s_q.osc[POS_FAST_OSC_ON];        // [R01]
      s_d.slow_en = !stop_now && !enter_stop && !s_q.osc[POS_SLOW_OSC_STOP];     // [R01]

      // System clock divider; restarts from zero on every stop.
      if (stop_now || enter_stop) begin
         s_d.div_cnt = 4'h0;
         s_d.sys_en  = 1'b0;
      end else if (s_q.div_cnt >= div_term(s_q.ctl0[POS_SYSCLK_DIV8_SEL],
                                           s_q.ctl1[POS_SYSCLK_DIV_FIELD_LO +: 2])) begin
         s_d.div_cnt = 4'h0;                                                   // [R07] [R16]
         s_d.sys_en  = 1'b1;
      end else begin
         s_d.div_cnt = s_q.div_cnt + 4'h1;
         s_d.sys_en  = 1'b0;
      end

      s_d.periph_en = !stop_now && !enter_stop
                      && !(WAIT_MODE_I && s_q.ctl0[POS_WAIT_PERIPH_CLK_GATE]);  // [R04]

      // Shared pins.
      if (s_q.ctl0[POS_XTAL_PIN_FUNCTION_SEL]) begin
         // The crystal amplifier owns the pins; its analog drive is outside this logic.
         s_d.pin_a = '{val: 1'b0, oe_b: 1'b1};                                  // [R06]
         s_d.pin_b = '{val: 1'b0, oe_b: 1'b1};                                  // [R06]
         if (stop_now) begin
            s_d.pin_a = '{val: 1'b0, oe_b: 1'b1};                               // [R11]
            s_d.pin_b = '{val: 1'b1, oe_b: 1'b0};                               // [R11]
         end
      end else if (stop_now) begin
         s_d.pin_a = '{val: s_q.hold_a.out, oe_b: !s_q.hold_a.dir};             // [R12]
         s_d.pin_b = '{val: s_q.hold_b.out, oe_b: !s_q.hold_b.dir};             // [R12]
      end else begin
         s_d.pin_a = '{val: PORT_A_OUT_I, oe_b: !PORT_A_DIR_I};                 // [R02] [R06]
         s_d.pin_b = '{val: PORT_B_OUT_I, oe_b: !PORT_B_DIR_I};                 // [R02] [R06]
      end

      // Read data stand in the cycle after the read strobe only.
      s_d.rd_data = 8'h00;
      if (bus.rd_stb) begin
         case (bus.addr)
            ADDR_CLOCK_CONTROL_ZERO: s_d.rd_data = s_q.ctl0 & MASK_CLOCK_CONTROL_ZERO; // [R13]
            ADDR_CLOCK_CONTROL_ONE:  s_d.rd_data = s_q.ctl1;
            ADDR_OSC_CONTROL:        s_d.rd_data = s_q.osc;
            ADDR_WRITE_PROTECT:      s_d.rd_data = s_q.prot;
            default:                 s_d.rd_data = 8'h00;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= STATE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================================
   // Outputs
   // ==========================================================================
   assign RD_DATA_O           = s_q.rd_data;
   assign PORT_A_IN_O         = s_q.flt_a;
   assign PORT_B_IN_O         = s_q.flt_b;
   assign SHARED_PIN_A_O      = s_q.pin_a.val;
   assign SHARED_PIN_A_OE_B_O = s_q.pin_a.oe_b;
   assign SHARED_PIN_B_O      = s_q.pin_b.val;
   assign SHARED_PIN_B_OE_B_O = s_q.pin_b.oe_b;
   assign XTAL_OSC_EN_O       = s_q.xtal_en;
   assign XTAL_DRIVE_HIGH_O   = s_q.ctl0[POS_XTAL_DRIVE_STRENGTH];              // [R05]
   assign FAST_OSC_EN_O       = s_q.fast_en;
   assign SLOW_OSC_EN_O       = s_q.slow_en;
   assign CPU_SRC_SEL_O       = s_q.osc[POS_CPU_SRC_LO +: 2];                  // [R01]
   assign PERIPH_SRC_SEL_O    = s_q.osc[POS_PERIPH_SRC_LO +: 2];               // [R01]
   assign SYS_CLK_EN_O        = s_q.sys_en;
   assign PERIPH_CLK_EN_O     = s_q.periph_en;
   assign STOP_MODE_O         = (s_q.mode == CSC_STOP);

   // ==========================================================================
   // Assertions
   // ==========================================================================
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!rst_b);

   AST_LOCKED_WRITE_IGNORED: assert property ( // [R08]
      (WR_STB_I && ADDR_I == ADDR_CLOCK_CONTROL_ZERO && !s_q.prot[0] && s_q.mode == CSC_RUN && !enter_stop)
      |=> $stable(s_q.ctl0))
      else $error("Locked control register zero changed.");

   AST_UNLOCKED_WRITE_TAKEN: assert property ( // [R08]
      (WR_STB_I && ADDR_I == ADDR_CLOCK_CONTROL_ZERO && s_q.prot[0] && s_q.mode == CSC_RUN)
      |=> s_q.ctl0 == ($past(WR_DATA_I) & MASK_CLOCK_CONTROL_ZERO))
      else $error("Unlocked write to control register zero not stored.");

   AST_UNUSED_BITS_ZERO: assert property ( // [R13]
      RD_STB_I && ADDR_I == ADDR_CLOCK_CONTROL_ZERO |=> RD_DATA_O[0] == 1'b0 && RD_DATA_O[5] == 1'b0)
      else $error("Unimplemented bits read nonzero.");

   AST_STOP_FORCES: assert property ( // [R09] [R10] [R17]
      enter_stop |=> STOP_MODE_O && XTAL_DRIVE_HIGH_O && s_q.ctl0[POS_SYSCLK_DIV8_SEL]
                     ##1 !XTAL_OSC_EN_O && !FAST_OSC_EN_O && !SLOW_OSC_EN_O)
      else $error("Stop entry did not force drive, divider or halt.");

   AST_STOP_XTAL_PINS: assert property ( // [R11]
      STOP_MODE_O && s_q.ctl0[POS_XTAL_PIN_FUNCTION_SEL] |=> SHARED_PIN_A_OE_B_O
                     && SHARED_PIN_B_O && !SHARED_PIN_B_OE_B_O)
      else $error("Crystal pins wrong in stop mode.");

   AST_STOP_PORT_HOLD: assert property ( // [R12]
      STOP_MODE_O && $past(STOP_MODE_O) && !s_q.ctl0[POS_XTAL_PIN_FUNCTION_SEL]
      |=> $stable(SHARED_PIN_A_O) && $stable(SHARED_PIN_A_OE_B_O) && $stable(SHARED_PIN_B_O))
      else $error("Port pins changed in stop mode.");

   AST_WAIT_GATE: assert property ( // [R04]
      WAIT_MODE_I && s_q.ctl0[POS_WAIT_PERIPH_CLK_GATE] |=> !PERIPH_CLK_EN_O)
      else $error("Peripheral clock ran in gated wait mode.");

   AST_DIV8_SPACING: assert property ( // [R07]
      SYS_CLK_EN_O && s_q.ctl0[POS_SYSCLK_DIV8_SEL] && !STOP_MODE_O && !enter_stop
      && $stable(s_q.ctl0) ##1 (!enter_stop && $stable(s_q.ctl0))[*7]
      |=> SYS_CLK_EN_O)
      else $error("Divide-by-8 enable spacing wrong.");

   AST_DIV16_GAP: assert property ( // [R16]
      SYS_CLK_EN_O && s_q.ctl1[7:6] == 2'h3 && !s_q.ctl0[POS_SYSCLK_DIV8_SEL]
      |=> (!SYS_CLK_EN_O || $past(s_q.ctl1[7:6]) != 2'h3 || $past(s_q.ctl0[POS_SYSCLK_DIV8_SEL]))[*8])
      else $error("Divide-by-16 enable came too early.");

   AST_PORT_ROUTE: assert property ( // [R06]
      !STOP_MODE_O && !s_q.ctl0[POS_XTAL_PIN_FUNCTION_SEL] && $stable(s_q.ctl0)
      |=> SHARED_PIN_A_O == $past(PORT_A_OUT_I) && SHARED_PIN_A_OE_B_O == !$past(PORT_A_DIR_I))
      else $error("Port function not routed to shared pin.");

endmodule
`default_nettype wire

// File: tb/csc_clock_source_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module csc_clock_source_control_tb_top;
   import csc_pkg::*;
   // ==========================================================================
   // Stimulus and observed signals
   // ==========================================================================
   logic       clk, rst_b, wr_stb, rd_stb, wait_mode, wake;
   logic       pa_out, pa_dir, pb_out, pb_dir;
   logic [7:0] addr, wdata, rd_data;
   logic       pa_o, pa_oe_b, pb_o, pb_oe_b, xtal_en, drv_hi, fast_en, slow_en, sys_en, per_en, stop;
   logic [1:0] cpu_src, per_src;
   logic       pin_a, pin_b, pa_in, pb_in;
   int         errors, comparisons;

   csc_clock_source_control i_dut (
      .CORE_CLK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr), .WR_DATA_I(wdata), .WR_STB_I(wr_stb),
      .RD_STB_I(rd_stb), .RD_DATA_O(rd_data), .WAIT_MODE_I(wait_mode), .WAKE_I(wake),
      .PORT_A_OUT_I(pa_out), .PORT_A_DIR_I(pa_dir), .PORT_B_OUT_I(pb_out), .PORT_B_DIR_I(pb_dir),
      .PORT_A_IN_O(pa_in), .PORT_B_IN_O(pb_in), .SHARED_PIN_A_I(pin_a), .SHARED_PIN_B_I(pin_b),
      .SHARED_PIN_A_O(pa_o), .SHARED_PIN_A_OE_B_O(pa_oe_b), .SHARED_PIN_B_O(pb_o),
      .SHARED_PIN_B_OE_B_O(pb_oe_b), .XTAL_OSC_EN_O(xtal_en), .XTAL_DRIVE_HIGH_O(drv_hi),
      .FAST_OSC_EN_O(fast_en), .SLOW_OSC_EN_O(slow_en), .CPU_SRC_SEL_O(cpu_src),
      .PERIPH_SRC_SEL_O(per_src), .SYS_CLK_EN_O(sys_en), .PERIPH_CLK_EN_O(per_en), .STOP_MODE_O(stop)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ==========================================================================
   // Bus and check tasks
   // ==========================================================================
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic chkb(input logic got, input logic exp, input string what);
      chk({7'h00, got}, {7'h00, exp}, what);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr   <= a;
      wdata  <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so it is sampled there.
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(posedge clk);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1;
      chk(rd_data, exp, what);
   endtask

   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask

   // Measures the spacing of system clock enable pulses in core clock cycles.
   task automatic period(input int exp, input string what);
      int n;
      repeat (20) @(negedge clk);
      for (n = 0; n < 64 && sys_en !== 1'b1; n++) @(negedge clk);
      @(negedge clk);
      n = 1;
      while (sys_en !== 1'b1 && n < 64) begin
         @(negedge clk);
         n++;
      end
      chk(8'(n), 8'(exp), what);
   endtask

   task automatic wake_up();
      int n;
      @(posedge clk);
      wake <= 1'b1;
      for (n = 0; n < 20 && stop !== 1'b0; n++) @(negedge clk);
      chkb(stop, 1'b0, "wake ends stop");
      @(posedge clk);
      wake <= 1'b0;
      repeat (10) @(posedge clk);
   endtask

   task automatic finish_test();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ==========================================================================
   // Test sequence
   // ==========================================================================
   initial begin
      errors = 0;
      comparisons = 0;
      rst_b = 1'b0;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      wait_mode = 1'b0;
      wake = 1'b0;
      pa_out = 1'b0;
      pa_dir = 1'b0;
      pb_out = 1'b0;
      pb_dir = 1'b0;
      pin_a = 1'b0;
      pin_b = 1'b0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      rd_chk(ADDR_CLOCK_CONTROL_ZERO, 8'h58, "ctl0 reset");
      rd_chk(ADDR_CLOCK_CONTROL_ONE, 8'h00, "ctl1 reset");
      rd_chk(ADDR_OSC_CONTROL, 8'hA0, "osc reset");
      rd_chk(ADDR_WRITE_PROTECT, 8'h00, "protect reset");
      rd_chk(8'h05, 8'h00, "unmapped read");
      settle();
      chkb(drv_hi, 1'b1, "drive after reset");
      chk({xtal_en, fast_en, slow_en}, 8'h05, "osc enables after reset");
      chk({pa_oe_b, pb_oe_b}, 8'h03, "crystal pins released");
      period(8, "div8 after reset");
      // The write lock must hold before the unlock bit is set.
      wr(ADDR_CLOCK_CONTROL_ZERO, 8'h00);
      rd_chk(ADDR_CLOCK_CONTROL_ZERO, 8'h58, "locked write ignored");
      wr(ADDR_WRITE_PROTECT, 8'h01);
      // Reserved bits 1 and 7 are written as 0; every other bit is set.
      wr(ADDR_CLOCK_CONTROL_ZERO, 8'h7D);
      pin_a <= 1'b1;
      rd_chk(ADDR_CLOCK_CONTROL_ZERO, 8'h5C, "unimplemented bits");
      // The crystal has run since reset, so its drive may be lowered now.
      wr(ADDR_CLOCK_CONTROL_ZERO, 8'h00);
      pa_out <= 1'b1;
      pa_dir <= 1'b1;
      pb_out <= 1'b0;
      pb_dir <= 1'b1;
      settle();
      chkb(drv_hi, 1'b0, "low drive");
      chk({pa_o, pa_oe_b, pb_o, pb_oe_b}, 8'h08, "port function drives pins");
      chk({pa_in, pb_in}, 8'h02, "pin levels synchronised");
      chkb(xtal_en, 1'b0, "crystal off in port mode");
      // Divider field codes 00, 01, 10, 11 give 1, 2, 4 and 16.
      for (int f = 0; f < 4; f++) begin
         wr(ADDR_CLOCK_CONTROL_ONE, {f[1:0], 6'h00});
         period(f == 3 ? 16 : (1 << f), "divider field");
      end
      wr(ADDR_CLOCK_CONTROL_ONE, 8'h00);
      wait_mode <= 1'b1;
      pin_a <= 1'b0;
      pin_b <= 1'b1;
      settle();
      chkb(per_en, 1'b1, "peripheral clock runs in wait");
      wr(ADDR_CLOCK_CONTROL_ZERO, 8'h04);
      settle();
      chkb(per_en, 1'b0, "peripheral clock gated in wait");
      chk({pa_in, pb_in}, 8'h01, "pin levels swapped");
      @(posedge clk);
      wait_mode <= 1'b0;
      settle();
      chkb(per_en, 1'b1, "peripheral clock after wait");
      wr(ADDR_OSC_CONTROL, 8'h16);
      settle();
      chk({fast_en, slow_en, cpu_src, per_src}, 8'h24, "fast on slow off");
      wr(ADDR_OSC_CONTROL, 8'h85);
      settle();
      chk({xtal_en, fast_en, slow_en, cpu_src, per_src}, 8'h02, "all stopped");
      wr(ADDR_OSC_CONTROL, 8'hA0);
      // Stop with port function: pins keep what they had at entry.
      pb_dir <= 1'b0;
      settle();
      wr(ADDR_CLOCK_CONTROL_ONE, 8'h01);
      pa_out <= 1'b0;
      pb_dir <= 1'b1;
      settle();
      chkb(stop, 1'b1, "stop entered");
      chk({xtal_en, fast_en, slow_en, per_en}, 8'h00, "clocks halted");
      chk({pa_o, pa_oe_b, pb_oe_b}, 8'h05, "port pins held in stop");
      period(64, "no system pulses in stop");
      wake_up();
      rd_chk(ADDR_CLOCK_CONTROL_ZERO, 8'h4C, "stop forces drive and div8");
      rd_chk(ADDR_CLOCK_CONTROL_ONE, 8'h00, "stop bit cleared");
      // Stop with crystal function: input floats, output driven high.
      wr(ADDR_CLOCK_CONTROL_ZERO, 8'h10);
      pa_dir <= 1'b0;
      settle();
      chk({drv_hi, pa_oe_b, pb_oe_b}, 8'h03, "crystal mode running");
      wr(ADDR_CLOCK_CONTROL_ONE, 8'h01);
      settle();
      chk({drv_hi, pa_oe_b, pb_o, pb_oe_b}, 8'h0E, "crystal pins in stop");
      wake_up();
      rd_chk(ADDR_CLOCK_CONTROL_ZERO, 8'h58, "forced bits after stop");
      period(8, "restart in div8");
      wr(ADDR_WRITE_PROTECT, 8'h00);
      wr(ADDR_CLOCK_CONTROL_ZERO, 8'h00);
      rd_chk(ADDR_CLOCK_CONTROL_ZERO, 8'h58, "relocked write ignored");
      finish_test();
   end

   initial begin
      #200000;
      errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      finish_test();
   end
endmodule
`default_nettype wire
